// file: include/uaf_pkg.sv
// constants for the APB serial port with send and receive queues
package uaf_pkg;
   localparam logic [7:0]  ADDR_SEND_BYTE    = 8'h00;
   localparam logic [7:0]  ADDR_RECEIVE_BYTE = 8'h04;
   localparam logic [7:0]  ADDR_LINE_FLAGS   = 8'h08;
   localparam logic [7:0]  ADDR_LINE_SETUP   = 8'h0c;
   localparam logic [7:0]  ADDR_BIT_PERIOD   = 8'h10;
   localparam logic [7:0]  ADDR_RESEND       = 8'h14;
   localparam logic [7:0]  ADDR_SEND_LOW     = 8'h18;
   localparam logic [7:0]  ADDR_RECV_HIGH    = 8'h1c;
   localparam logic [7:0]  ADDR_SWIN_BEGIN   = 8'h20;
   localparam logic [7:0]  ADDR_SWIN_SPAN    = 8'h24;
   localparam logic [7:0]  ADDR_RWIN_BEGIN   = 8'h28;
   localparam logic [7:0]  ADDR_RWIN_SPAN    = 8'h2c;
   localparam logic [7:0]  ADDR_SEND_FILL    = 8'h30;
   localparam logic [7:0]  ADDR_RECV_FILL    = 8'h34;
   localparam logic [7:0]  ADDR_GAP_TIME     = 8'h38;
   localparam logic [7:0]  ADDR_IDLE_LIMIT   = 8'h3c;
   localparam logic [7:0]  ADDR_IDLE_COUNT   = 8'h40;
   // line_flags bit positions
   localparam int F_SQ_EMPTY = 0;
   localparam int F_SQ_FULL  = 1;
   localparam int F_SQ_OVF   = 2;
   localparam int F_RQ_EMPTY = 3;
   localparam int F_RQ_FULL  = 4;
   localparam int F_RQ_OVF   = 5;
   localparam int F_HEAD_PAR = 6;
   localparam int F_BREAK    = 7;
   localparam int F_FRAMING  = 8;
   localparam int F_PARITY   = 9;
   localparam int F_RETRY    = 10;
   localparam int F_IDLE_EXP = 11;
   localparam int F_SQ_LOW   = 13;
   localparam int F_RQ_HIGH  = 14;
   // line_setup bit positions
   localparam int C_ENABLE   = 0;
   localparam int C_TWO_STOP = 1;
   localparam int C_SEVEN    = 2;
   localparam int C_PAR_LSB  = 3;
   localparam int C_FLOWCTL  = 6;
   localparam int C_BREAK_TX = 7;
   localparam int C_FIFO_RST = 13;
   localparam int C_DUPLEX   = 15;
   localparam logic [15:0] SETUP_RESET   = 16'h0000;
   localparam logic [15:0] DIVISOR_RESET = 16'h0015;
   localparam logic [31:0] WORD_ZERO     = 32'h0000_0000;
   // parity schemes
   localparam logic [2:0] PAR_NONE  = 3'h0;
   localparam logic [2:0] PAR_EVEN  = 3'h1;
   localparam logic [2:0] PAR_ODD   = 3'h2;
   localparam logic [2:0] PAR_MARK  = 3'h3;
   localparam logic [2:0] PAR_SPACE = 3'h4;
   typedef enum logic [2:0] {
      SER_IDLE  = 3'b000,
      SER_START = 3'b001,
      SER_DATA  = 3'b011,
      SER_PAR   = 3'b010,
      SER_STOP  = 3'b110
   } uaf_ser_e;
endpackage

// file: rtl/uaf_serial_port.sv
// APB serial port with send and receive queues, flow control and DMA handshake
`timescale 1ns/1ps
`default_nettype none
module uaf_serial_port
   import uaf_pkg::*;
#(
   parameter logic [15:0] DIVISOR_INIT = DIVISOR_RESET,
   parameter int          SEND_DEPTH   = 4,
   parameter int          RECV_DEPTH   = 4,
   parameter bit          SMARTCARD    = 1'b0
)(
   // clock and reset
   input  wire logic        i_clock,
   input  wire logic        i_sys_rst,
   // register port
   input  wire logic [31:0] i_paddr,
   input  wire logic        i_psel,
   input  wire logic        i_penable,
   input  wire logic        i_pwrite,
   input  wire logic        i_debug_peek,
   input  wire logic [31:0] i_pwdata,
   output logic             o_pready,
   output logic [31:0]      o_prdata,
   output logic             o_pslverr,
   // serial line
   input  wire logic        i_serial_in,
   input  wire logic        i_clear_send_in_n,
   output logic             o_serial_out,
   output logic             o_request_send_out_n,
   output logic             o_duplex,
   output logic             o_clock_request,
   // dma handshake
   input  wire logic        i_send_dma_done,
   input  wire logic        i_recv_dma_done,
   output logic             o_send_dma_req,
   output logic             o_recv_dma_req
);
   localparam int SW = $clog2(SEND_DEPTH);
   localparam int RW = $clog2(RECV_DEPTH);

   // depth check at elaboration
   if (SEND_DEPTH < 2 || (SEND_DEPTH & (SEND_DEPTH - 1)) != 0 ||
       RECV_DEPTH < 2 || (RECV_DEPTH & (RECV_DEPTH - 1)) != 0) begin : g_bad_depth
      $error("queue depths must be powers of two and at least two");
   end

   function automatic logic par_bit(input logic [7:0] d, input logic seven,
                                    input logic [2:0] mode);
      logic x;
      x = seven ? ^d[6:0] : ^d;
      case (mode)
         PAR_EVEN:  par_bit = x;
         PAR_ODD:   par_bit = ~x;
         PAR_MARK:  par_bit = 1'b1;
         default:   par_bit = 1'b0;
      endcase
   endfunction

   // register bus decode
   logic [7:0] addr;
   logic       wr_en;
   logic       rd_en;
   assign addr  = i_paddr[7:0];
   assign wr_en = i_psel & i_penable & i_pwrite;
   assign rd_en = i_psel & i_penable & ~i_pwrite;
   assign o_pready  = 1'b1;
   assign o_pslverr = 1'b0;

   logic [15:0] setup;
   logic [15:0] divisor;
   logic [31:0] resend, send_low, recv_high, swin_b, swin_s, rwin_b, rwin_s;
   logic [31:0] gap_time, idle_limit, idle_count;
   logic        sq_ovf, rq_ovf, brk_f, frm_f, par_f, retry_f, idle_f;

   wire enable   = setup[C_ENABLE];
   wire fifo_clr = wr_en && addr == ADDR_LINE_SETUP && i_pwdata[C_FIFO_RST];
   wire [2:0] par_mode = setup[C_PAR_LSB +: 3];

   // send queue: two-sided valid/ready store
   logic [7:0]  sq_mem [SEND_DEPTH];
   logic [SW:0] sq_cnt;
   logic [SW-1:0] sq_rd, sq_wr;
   wire sq_full  = sq_cnt == (SW+1)'(SEND_DEPTH);
   wire sq_empty = sq_cnt == '0;
   wire sq_push_req = wr_en && addr == ADDR_SEND_BYTE;
   wire sq_push = sq_push_req && !sq_full;
   logic tx_take;
   wire sq_pop = tx_take && !sq_empty;

   always_ff @(posedge i_clock or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         sq_cnt <= '0;
         sq_rd  <= '0;
         sq_wr  <= '0;
      end else if (fifo_clr) begin
         sq_cnt <= '0;
         sq_rd  <= '0;
         sq_wr  <= '0;
      end else begin
         if (sq_push) sq_wr <= sq_wr + 1'b1;
         if (sq_pop)  sq_rd <= sq_rd + 1'b1;
         sq_cnt <= sq_cnt + (SW+1)'(sq_push) - (SW+1)'(sq_pop);
      end
   end
   always_ff @(posedge i_clock) begin
      if (sq_push) sq_mem[sq_wr] <= i_pwdata[7:0];
   end

   // receive queue, each entry carries its parity bit
   logic [8:0]  rq_mem [RECV_DEPTH];
   logic [RW:0] rq_cnt;
   logic [RW-1:0] rq_rd, rq_wr;
   wire rq_full  = rq_cnt == (RW+1)'(RECV_DEPTH);
   wire rq_empty = rq_cnt == '0;
   logic       rx_push_req;
   logic [8:0] rx_word;
   wire rq_push = rx_push_req && !rq_full;
   wire rq_pop  = rd_en && addr == ADDR_RECEIVE_BYTE && !i_debug_peek && !rq_empty;
   wire [8:0] rq_head = rq_mem[rq_rd];

   always_ff @(posedge i_clock or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         rq_cnt <= '0;
         rq_rd  <= '0;
         rq_wr  <= '0;
      end else if (fifo_clr) begin
         rq_cnt <= '0;
         rq_rd  <= '0;
         rq_wr  <= '0;
      end else begin
         if (rq_push) rq_wr <= rq_wr + 1'b1;
         if (rq_pop)  rq_rd <= rq_rd + 1'b1;
         rq_cnt <= rq_cnt + (RW+1)'(rq_push) - (RW+1)'(rq_pop);
      end
   end
   always_ff @(posedge i_clock) begin
      if (rq_push) rq_mem[rq_wr] <= rx_word;
   end

   wire sq_low  = 32'(sq_cnt) < send_low[31:0];
   wire rq_high = 32'(rq_cnt) > recv_high[31:0];
   assign o_send_dma_req = sq_low;
   assign o_recv_dma_req = !rq_empty;
   // rts high only when receive fill is above recv_high and flow control is on
   assign o_request_send_out_n = setup[C_FLOWCTL] & rq_high;
   assign o_duplex = SMARTCARD ? setup[C_DUPLEX] : 1'b0;
   assign o_clock_request = enable | !sq_empty;

   // transmitter
   uaf_ser_e    tx_st;
   logic [15:0] tx_tick;
   logic [3:0]  tx_bit;
   logic [7:0]  tx_sh;
   logic        tx_par, tx_out, tx_stop2;
   wire tx_tick_end = tx_tick == divisor;
   wire [3:0] nbits = setup[C_SEVEN] ? 4'h7 : 4'h8;
   assign tx_take = tx_st == SER_IDLE && enable && !sq_empty &&
                    !(setup[C_FLOWCTL] && i_clear_send_in_n);

   always_ff @(posedge i_clock or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         tx_st <= SER_IDLE;
         tx_tick <= 16'h0000;
         tx_bit <= 4'h0;
         tx_sh <= 8'h00;
         tx_par <= 1'b0;
         tx_out <= 1'b1;
         tx_stop2 <= 1'b0;
      end else begin
         tx_tick <= (tx_st == SER_IDLE || tx_tick_end) ? 16'h0000 : tx_tick + 16'h0001;
         case (tx_st)
            SER_IDLE: begin
               tx_out <= 1'b1;
               if (tx_take) begin
                  tx_sh  <= sq_mem[sq_rd];
                  tx_par <= par_bit(sq_mem[sq_rd], setup[C_SEVEN], par_mode);
                  tx_out <= 1'b0;
                  tx_bit <= 4'h0;
                  tx_st  <= SER_START;
               end
            end
            SER_START: if (tx_tick_end) begin
               tx_out <= tx_sh[0];
               tx_st  <= SER_DATA;
            end
            SER_DATA: if (tx_tick_end) begin
               if (tx_bit == nbits - 4'h1) begin
                  tx_out <= (par_mode == PAR_NONE) ? 1'b1 : tx_par;
                  tx_st  <= (par_mode == PAR_NONE) ? SER_STOP : SER_PAR;
                  tx_stop2 <= setup[C_TWO_STOP];
               end else begin
                  tx_out <= tx_sh[1];
                  tx_sh  <= {1'b0, tx_sh[7:1]};
                  tx_bit <= tx_bit + 4'h1;
               end
            end
            SER_PAR: if (tx_tick_end) begin
               tx_out <= 1'b1;
               tx_st  <= SER_STOP;
            end
            SER_STOP: if (tx_tick_end) begin
               if (tx_stop2) tx_stop2 <= 1'b0;
               else tx_st <= SER_IDLE;
            end
            default: tx_st <= SER_IDLE;
         endcase
      end
   end
   assign o_serial_out = tx_out & ~setup[C_BREAK_TX];

   // receiver
   uaf_ser_e    rx_st;
   logic [15:0] rx_tick;
   logic [3:0]  rx_bit;
   logic [7:0]  rx_sh;
   logic        rx_par, rx_zero, rx_stop2, rx_prev;
   logic        rx_brk, rx_frm, rx_perr, rx_done;
   wire rx_half = rx_tick == {1'b0, divisor[15:1]};
   wire rx_end  = rx_tick == divisor;

   always_ff @(posedge i_clock or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         rx_st <= SER_IDLE;
         rx_tick <= 16'h0000;
         rx_bit <= 4'h0;
         rx_sh <= 8'h00;
         rx_par <= 1'b0;
         rx_zero <= 1'b1;
         rx_stop2 <= 1'b0;
         rx_prev <= 1'b1;
         rx_brk <= 1'b0;
         rx_frm <= 1'b0;
         rx_perr <= 1'b0;
         rx_done <= 1'b0;
      end else begin
         rx_prev <= i_serial_in;
         rx_brk <= 1'b0;
         rx_frm <= 1'b0;
         rx_perr <= 1'b0;
         rx_done <= 1'b0;
         rx_tick <= (rx_st == SER_IDLE || rx_end) ? 16'h0000 : rx_tick + 16'h0001;
         if (!enable) begin
            rx_st <= SER_IDLE;
         end else begin
            case (rx_st)
               SER_IDLE: if (rx_prev && !i_serial_in) begin
                  rx_st <= SER_START;
                  rx_bit <= 4'h0;
                  rx_zero <= 1'b1;
                  rx_stop2 <= setup[C_TWO_STOP];
               end
               SER_START: if (rx_half) begin
                  if (i_serial_in) rx_st <= SER_IDLE; // start glitch
               end else if (rx_end) rx_st <= SER_DATA;
               SER_DATA: if (rx_half) begin
                  rx_sh <= setup[C_SEVEN] ? {1'b0, i_serial_in, rx_sh[6:1]}
                                          : {i_serial_in, rx_sh[7:1]};
                  rx_zero <= rx_zero & ~i_serial_in;
                  rx_bit <= rx_bit + 4'h1;
               end else if (rx_end && rx_bit == nbits) begin
                  rx_st <= (par_mode == PAR_NONE) ? SER_STOP : SER_PAR;
               end
               SER_PAR: if (rx_half) begin
                  rx_par <= i_serial_in;
                  rx_zero <= rx_zero & ~i_serial_in;
               end else if (rx_end) rx_st <= SER_STOP;
               SER_STOP: if (rx_half) begin
                  if (!i_serial_in) begin
                     rx_brk <= rx_zero;
                     rx_frm <= !rx_zero;
                     rx_st <= SER_IDLE;
                  end else if (!rx_stop2) begin
                     rx_done <= 1'b1;
                     rx_perr <= par_mode != PAR_NONE &&
                                rx_par != par_bit(rx_sh, setup[C_SEVEN], par_mode);
                     rx_st <= SER_IDLE;
                  end
               end else if (rx_end) rx_stop2 <= 1'b0;
               default: rx_st <= SER_IDLE;
            endcase
         end
      end
   end
   assign rx_push_req = rx_done;
   assign rx_word = {(par_mode == PAR_NONE) ? 1'b0 : rx_par, rx_sh};

   // register file; set wins over a clearing write
   wire        flag_wr = wr_en && addr == ADDR_LINE_FLAGS;
   wire [31:0] clr     = flag_wr ? i_pwdata : WORD_ZERO;
   always_ff @(posedge i_clock or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         setup <= SETUP_RESET;
         divisor <= DIVISOR_INIT;
         {resend, send_low, recv_high, swin_b, swin_s, rwin_b, rwin_s} <= '0;
         {gap_time, idle_limit, idle_count} <= '0;
         {sq_ovf, rq_ovf, brk_f, frm_f, par_f, retry_f, idle_f} <= '0;
      end else begin
         if (wr_en) begin
            case (addr)
               ADDR_LINE_SETUP: setup <= i_pwdata[15:0] & ~(16'h0001 << C_FIFO_RST);
               ADDR_BIT_PERIOD: divisor <= i_pwdata[15:0];
               ADDR_RESEND:     resend <= i_pwdata;
               ADDR_SEND_LOW:   send_low <= i_pwdata;
               ADDR_RECV_HIGH:  recv_high <= i_pwdata;
               ADDR_SWIN_BEGIN: swin_b <= i_pwdata;
               ADDR_SWIN_SPAN:  swin_s <= i_pwdata;
               ADDR_RWIN_BEGIN: rwin_b <= i_pwdata;
               ADDR_RWIN_SPAN:  rwin_s <= i_pwdata;
               ADDR_GAP_TIME:   gap_time <= i_pwdata;
               ADDR_IDLE_LIMIT: idle_limit <= i_pwdata;
               ADDR_IDLE_COUNT: idle_count <= i_pwdata;
               default: ;
            endcase
         end
         sq_ovf <= (sq_push_req && sq_full) | (sq_ovf & ~clr[F_SQ_OVF]);
         rq_ovf <= (rx_push_req && rq_full) | (rq_ovf & ~clr[F_RQ_OVF]);
         brk_f  <= rx_brk | (brk_f & ~clr[F_BREAK]);
         frm_f  <= rx_frm | (frm_f & ~clr[F_FRAMING]);
         par_f  <= rx_perr | (par_f & ~clr[F_PARITY]);
         retry_f <= SMARTCARD & retry_f & ~clr[F_RETRY];
         idle_f  <= SMARTCARD & idle_f & ~clr[F_IDLE_EXP];
      end
   end

   logic [31:0] flags;
   always_comb begin
      flags = WORD_ZERO;
      flags[F_SQ_EMPTY] = sq_empty;
      flags[F_SQ_FULL]  = sq_full;
      flags[F_SQ_OVF]   = sq_ovf;
      flags[F_RQ_EMPTY] = rq_empty;
      flags[F_RQ_FULL]  = rq_full;
      flags[F_RQ_OVF]   = rq_ovf;
      flags[F_HEAD_PAR] = rq_empty ? 1'b0 : rq_head[8];
      flags[F_BREAK]    = brk_f;
      flags[F_FRAMING]  = frm_f;
      flags[F_PARITY]   = par_f;
      flags[F_RETRY]    = retry_f;
      flags[F_IDLE_EXP] = idle_f;
      flags[F_SQ_LOW]   = sq_low;
      flags[F_RQ_HIGH]  = rq_high;
   end

   logic [31:0] rd_mux;
   always_comb begin
      case (addr)
         ADDR_RECEIVE_BYTE: rd_mux = {24'h00_0000, rq_head[7:0]};
         ADDR_LINE_FLAGS:   rd_mux = flags;
         ADDR_LINE_SETUP:   rd_mux = {16'h0000, setup};
         ADDR_BIT_PERIOD:   rd_mux = {16'h0000, divisor};
         ADDR_RESEND:       rd_mux = resend;
         ADDR_SEND_LOW:     rd_mux = send_low;
         ADDR_RECV_HIGH:    rd_mux = recv_high;
         ADDR_SWIN_BEGIN:   rd_mux = swin_b;
         ADDR_SWIN_SPAN:    rd_mux = swin_s;
         ADDR_RWIN_BEGIN:   rd_mux = rwin_b;
         ADDR_RWIN_SPAN:    rd_mux = rwin_s;
         ADDR_SEND_FILL:    rd_mux = 32'(sq_cnt);
         ADDR_RECV_FILL:    rd_mux = 32'(rq_cnt);
         ADDR_GAP_TIME:     rd_mux = gap_time;
         ADDR_IDLE_LIMIT:   rd_mux = idle_limit;
         ADDR_IDLE_COUNT:   rd_mux = idle_count;
         default:           rd_mux = WORD_ZERO;
      endcase
   end
   assign o_prdata = rd_mux;

   // checks
   property p_no_push_full;
      @(posedge i_clock) disable iff (i_sys_rst)
      sq_full && !fifo_clr && !sq_pop |=> sq_full;
   endproperty
   a_no_push_full: assert property (p_no_push_full) else $error("send queue changed while full");
   property p_ovf_sticky;
      @(posedge i_clock) disable iff (i_sys_rst)
      sq_ovf && !clr[F_SQ_OVF] |=> sq_ovf;
   endproperty
   a_ovf_sticky: assert property (p_ovf_sticky) else $error("overflow flag lost");
   property p_peek;
      @(posedge i_clock) disable iff (i_sys_rst)
      rd_en && addr == ADDR_RECEIVE_BYTE && i_debug_peek && !fifo_clr && !rq_push
         |=> rq_cnt == $past(rq_cnt);
   endproperty
   a_peek: assert property (p_peek) else $error("peek popped the queue");
   property p_fault_nopush;
      @(posedge i_clock) disable iff (i_sys_rst)
      rx_brk || rx_frm |=> rq_cnt <= $past(rq_cnt);
   endproperty
   a_fault_nopush: assert property (p_fault_nopush) else $error("faulty character stored");
   property p_dis_idle;
      @(posedge i_clock) disable iff (i_sys_rst)
      !enable && tx_st == SER_IDLE |=> tx_st == SER_IDLE;
   endproperty
   a_dis_idle: assert property (p_dis_idle) else $error("sent while disabled");
   property p_rst_clears;
      @(posedge i_clock) disable iff (i_sys_rst)
      fifo_clr |=> sq_empty && rq_empty && !setup[C_FIFO_RST];
   endproperty
   a_rst_clears: assert property (p_rst_clears) else $error("queue reset failed");
   property p_bit_len;
      @(posedge i_clock) disable iff (i_sys_rst)
      tx_st == SER_START && tx_tick == 16'h0000 && divisor == 16'h0003
         |-> (tx_st == SER_START)[*4] ##1 tx_st == SER_DATA;
   endproperty
   a_bit_len: assert property (p_bit_len) else $error("bit length wrong");
   property p_nowait;
      @(posedge i_clock) disable iff (i_sys_rst)
      i_psel |-> o_pready && !o_pslverr;
   endproperty
   a_nowait: assert property (p_nowait) else $error("wait or error on bus");
endmodule
`default_nettype wire

// file: tb/uaf_far_end.sv
// far-end serial device: decodes the sent line, drives frames onto the received line
`timescale 1ns/1ps
`default_nettype none
module uaf_far_end #(
   parameter int BIT = 4
)(
   input  wire logic i_clock,
   input  wire logic i_line,
   output var logic  o_line
);
   logic [7:0] got[$];
   logic [7:0] b;
   initial o_line = 1'b1;
   // frame bits lsb first, start included; changed on the falling edge
   task automatic send(input logic [10:0] w, input int n);
      for (int i = 0; i < n; i++) begin
         o_line = w[i];
         repeat (BIT) @(negedge i_clock);
      end
      o_line = 1'b1;
      // one idle bit, so a low stop is followed by a visible rising edge
      repeat (BIT) @(negedge i_clock);
   endtask
   // sample mid-bit; a low stop bit drops the character
   always begin
      @(negedge i_line);
      repeat (BIT / 2) @(negedge i_clock);
      for (int i = 0; i < 8; i++) begin
         repeat (BIT) @(negedge i_clock);
         b[i] = i_line;
      end
      repeat (BIT) @(negedge i_clock);
      if (i_line) got.push_back(b);
   end
endmodule
`default_nettype wire

// file: tb/uaf_serial_port_tb.sv
// self-checking bench for the serial port with send and receive queues
`timescale 1ns/1ps
`default_nettype none
module uaf_serial_port_tb;
   import uaf_pkg::*;
   logic        clk, rst, psel, pen, pwr, peek, sdone, rdone, cts_n;
   logic [31:0] paddr, pwdata, prdata, r;
   logic        pready, pslverr, ser_tx, ser_rx, rts_n, duplex, creq, sreq, rreq;
   int          n_mismatch, n_tests, seed, sq[$], rq[$];
   uaf_serial_port dut (.i_clock(clk), .i_sys_rst(rst), .i_paddr(paddr), .i_psel(psel),
      .i_penable(pen), .i_pwrite(pwr), .i_debug_peek(peek), .i_pwdata(pwdata),
      .o_pready(pready), .o_prdata(prdata), .o_pslverr(pslverr), .i_serial_in(ser_rx),
      .i_clear_send_in_n(cts_n), .o_serial_out(ser_tx), .o_request_send_out_n(rts_n),
      .o_duplex(duplex), .o_clock_request(creq), .i_send_dma_done(sdone),
      .i_recv_dma_done(rdone), .o_send_dma_req(sreq), .o_recv_dma_req(rreq));
   uaf_far_end #(.BIT(4)) far (.i_clock(clk), .i_line(ser_tx), .o_line(ser_rx));
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic print_verdict;
      $display("checks %0d mismatches %0d", n_tests, n_mismatch);
      if (n_mismatch == 0 && n_tests > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   // high address bits are junk on purpose: only the low byte decodes
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(negedge clk);
      {sdone, rdone} = 2'b00;
      {psel, pwr, paddr, pwdata} = {1'b1, w, 24'h5a_a5c3, a, d};
      @(negedge clk);
      pen = 1'b1;
      #12;
      r = prdata;
      chk({30'h0000_0000, pready, pslverr}, 32'h0000_0002);
      @(posedge clk);
      @(negedge clk);
      {psel, pen} = 2'b00;
      sdone = w && a == ADDR_SEND_BYTE;
      rdone = !w && a == ADDR_RECEIVE_BYTE && !peek;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0000_0000);
      chk(r, exp);
   endtask
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   // whole run is well under a thousand cycles
   initial begin
      repeat (4000) @(posedge clk);
      n_mismatch++;
      print_verdict();
   end
   initial begin
      {psel, pen, pwr, peek, sdone, rdone, paddr, pwdata} = '0;
      cts_n = 1'b0;
      seed = 16;
      rst = 1'b1;
      repeat (5) @(negedge clk);
      rst = 1'b0;
      chk({27'h000_0000, duplex, sreq, rreq, rts_n, creq}, 32'h0000_0000);
      rd(ADDR_BIT_PERIOD, {16'h0000, DIVISOR_RESET});
      rd(ADDR_LINE_FLAGS, 32'h0000_0009);
      wr(ADDR_BIT_PERIOD, 32'h0000_0003);
      // unit disabled: fill past full, the last word is refused
      for (int i = 0; i < 5; i++) begin
         sq.push_back($random(seed) & 8'hff);
         wr(ADDR_SEND_BYTE, {24'hab_cdef, 8'(sq[$])});
      end
      rd(ADDR_SEND_FILL, 32'h0000_0004);
      chk({31'h0000_0000, creq}, 32'h0000_0001);
      rd(ADDR_LINE_FLAGS, 32'h0000_000e);
      wr(ADDR_LINE_FLAGS, 32'h0000_0004);
      rd(ADDR_LINE_FLAGS, 32'h0000_000a);
      repeat (60) @(negedge clk);
      chk(32'(far.got.size()), 32'h0000_0000);
      wr(ADDR_LINE_SETUP, 32'h0000_2000);
      rd(ADDR_SEND_FILL, 32'h0000_0000);
      rd(ADDR_LINE_SETUP, 32'h0000_0000);
      sq.delete();
      wr(ADDR_SEND_LOW, 32'h0000_0002);
      wr(ADDR_LINE_SETUP, 32'h0000_0001);
      chk({31'h0000_0000, sreq}, 32'h0000_0001);
      for (int i = 0; i < 3; i++) begin
         sq.push_back($random(seed) & 8'hff);
         wr(ADDR_SEND_BYTE, {24'h12_3456, 8'(sq[$])});
      end
      repeat (150) @(negedge clk);
      chk(32'(far.got.size()), 32'h0000_0003);
      foreach (sq[i]) chk(32'(far.got[i]), 32'(sq[i]));
      for (int i = 0; i < 2; i++) begin
         rq.push_back($random(seed) & 8'hff);
         far.send({2'b11, 8'(rq[$]), 1'b0}, 10);
      end
      repeat (8) @(negedge clk);
      chk({31'h0000_0000, rreq}, 32'h0000_0001);
      rd(ADDR_RECV_FILL, 32'h0000_0002);
      peek = 1'b1;
      rd(ADDR_RECEIVE_BYTE, 32'(rq[0]));
      peek = 1'b0;
      rd(ADDR_RECV_FILL, 32'h0000_0002);
      foreach (rq[i]) rd(ADDR_RECEIVE_BYTE, 32'(rq[i]));
      rd(ADDR_LINE_FLAGS, 32'h0000_2009);
      // low stop bit, then an all-zero break
      far.send({2'b10, 8'h55, 1'b0}, 10);
      far.send({2'b10, 8'h00, 1'b0}, 10);
      repeat (8) @(negedge clk);
      rd(ADDR_LINE_FLAGS, 32'h0000_2189);
      wr(ADDR_LINE_FLAGS, 32'h0000_0180);
      rd(ADDR_LINE_FLAGS, 32'h0000_2009);
      // even parity, wrong parity bit sent
      wr(ADDR_LINE_SETUP, 32'h0000_0009);
      far.send({2'b11, 8'h03, 1'b0}, 11);
      repeat (8) @(negedge clk);
      rd(ADDR_LINE_FLAGS, 32'h0000_6241);
      // flow control: receive fill above level raises rts_n, cts_n high holds the sender
      cts_n = 1'b1;
      wr(ADDR_LINE_SETUP, 32'h0000_0041);
      chk({31'h0000_0000, rts_n}, 32'h0000_0001);
      sq.push_back($random(seed) & 8'hff);
      wr(ADDR_SEND_BYTE, {24'h00_0000, 8'(sq[$])});
      repeat (60) @(negedge clk);
      chk(32'(far.got.size()), 32'h0000_0003);
      cts_n = 1'b0;
      repeat (60) @(negedge clk);
      chk(32'(far.got[3]), 32'(sq[3]));
      rd(ADDR_RECEIVE_BYTE, 32'h0000_0003);
      chk({31'h0000_0000, rts_n}, 32'h0000_0000);
      // seven data bits, odd parity, two stop bits
      wr(ADDR_LINE_SETUP, 32'h0000_0017);
      far.send({3'b111, 7'h35, 1'b0}, 11);
      rd(ADDR_RECEIVE_BYTE, 32'h0000_0035);
      print_verdict();
   end
endmodule
`default_nettype wire
